/* File: crg_pkg.sv */
// Purpose: Shared constants for the charger control 3 / status 0 register block
// Assumes: 8-bit register port, 40 MHz ref_clk
// Notes: Field positions are bit indices inside the 8-bit register
package crg_pkg;
  // Register offsets
  localparam logic [7:0] CTRL3_ADDR = 8'h07;
  localparam logic [7:0] STATUS0_ADDR = 8'h08;
  // Control register reset value
  localparam logic [7:0] CTRL3_RESET = 8'h4C;
  // Control field positions
  localparam int DETECT_BIT = 7;
  localparam int HALF_RATE_BIT = 6;
  localparam int SWITCH_DIS_BIT = 5;
  localparam int RESET_ADAPTER_BIT = 4;
  localparam int DELAY_SEL_BIT = 3;
  localparam int SYS_RESET_EN_BIT = 2;
  localparam int TRACK_HI = 1;
  localparam int TRACK_LO = 0;
  // Fields that watchdog expiry also restores
  localparam logic [7:0] WATCHDOG_MASK = 8'hC4;
  // Status field positions
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 5;
  localparam int PHASE_HI = 4;
  localparam int PHASE_LO = 3;
  localparam int PGOOD_BIT = 2;
  localparam int THERM_BIT = 1;
  localparam int MINSYS_BIT = 0;
  // Tracking offsets in mV
  localparam logic [15:0] TRACK_MV_01 = 16'h00C8;
  localparam logic [15:0] TRACK_MV_10 = 16'h00FA;
  localparam logic [15:0] TRACK_MV_11 = 16'h012C;
  // Switch-off delay timing
  localparam int CLK_HZ = 40000000;
  localparam int SWITCH_OFF_DELAY_S = 10;
  localparam int SWITCH_OFF_DELAY_CYCLES = SWITCH_OFF_DELAY_S * CLK_HZ;
  localparam int DELAY_CNT_W = 29;
  // Ship-mode sequencer states
  typedef enum logic [3:0] {
    SW_ON = 4'h1,
    SW_DELAY = 4'h2,
    SW_PEND = 4'h4,
    SW_OFF = 4'h8
  } crg_switch_e;
endpackage : crg_pkg

/* File: crg_delay_timer.sv */
// Purpose: Counts the battery switch-off delay while run is high
// Assumes: run drops to clear the count
// Notes: done pulses once when the count reaches CYCLES
`timescale 1ns/10ps
module crg_delay_timer #(
  parameter int CYCLES = crg_pkg::SWITCH_OFF_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic done
);
  // Timer state
  typedef struct packed {
    logic [crg_pkg::DELAY_CNT_W-1:0] count;
    logic done;
  } crg_timer_s;

  localparam logic [crg_pkg::DELAY_CNT_W-1:0] LAST = crg_pkg::DELAY_CNT_W'(CYCLES - 1);

  crg_timer_s state;
  crg_timer_s next_state;

  //////////////////////////////////////////////////////////////////////
  // Next state: count while running, pulse at the end, then hold
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (!run) begin
      // Abandon any partial count
      next_state.count = '0;
    end else if (state.count == LAST) begin
      // Stepping past LAST keeps done to a single pulse
      next_state.done = 1'b1;
      next_state.count = state.count + 1'b1;
    end else if (state.count < LAST) begin
      next_state.count = state.count + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done = state.done;
endmodule : crg_delay_timer

/* File: crg_control3_status0_regs.sv */
// Purpose: Charger control 3 and status 0 registers with ship-mode sequencing
// Assumes: Register port is the internal side of the serial interface
// Notes: All inputs synchronous to ref_clk; outputs registered
//
// Summary of operation
// - Detect request forces detection, self-clears when done
// - Half-rate safety timer during DPM, cool/warm, thermal
// - Switch disable 1 enters ship mode, switch off
// - Reset-with-adapter 0 waits for adapter removal
// - Delay select picks immediate or 10 s off
// - System reset needs reset enable and disable
// - Input limit is max of programmed, battery+offset
// - Control at 07h resets 4Ch; watchdog restores some
// - Source status codes none, USB, adapter, boost
// - Charge phase codes idle, precharge, fast, done
// - Power good and thermal regulation flags
// - Minimum system regulation flag
// - Status at 08h read-only and live
// - Software register reset restores all defaults
// - Watchdog expiry restores watchdog-marked fields
`timescale 1ns/10ps
module crg_control3_status0_regs #(
  parameter int SWITCH_OFF_DELAY_CYCLES = crg_pkg::SWITCH_OFF_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // Reset sources
  input wire logic softRegReset,
  input wire logic watchdogExpired,
  // Charger state inputs
  input wire logic adapterPresent,
  input wire logic detectDone,
  input wire logic [2:0] sourceType,
  input wire logic [1:0] chargePhase,
  input wire logic powerGood,
  input wire logic thermalReg,
  input wire logic minSysReg,
  input wire logic inInputDpm,
  input wire logic tempCoolWarm,
  input wire logic [15:0] inputLimitMv,
  input wire logic [15:0] batteryMv,
  // Outputs to the charger
  output logic [7:0] controlValue,
  output logic detectRequest,
  output logic timerHalfRate,
  output logic batterySwitchOn,
  output logic systemResetStart,
  output logic [15:0] effectiveLimitMv
);
  // Whole block state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] status;
    logic [7:0] readData;
    crg_pkg::crg_switch_e sw;
    logic switchOn;
    logic resetPulse;
    logic detectReq;
    logic halfRate;
    logic [15:0] limit;
  } crg_regs_s;

  crg_regs_s state;
  crg_regs_s next_state;
  logic delayDone; // One-cycle pulse from the delay timer
  logic delayRun; // Timer runs only while waiting to open

  //////////////////////////////////////////////////////////////////////
  // Switch-off delay counter
  assign delayRun = (state.sw == crg_pkg::SW_DELAY);

  crg_delay_timer #(
    .CYCLES(SWITCH_OFF_DELAY_CYCLES)
  ) offTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(delayRun),
    .done(delayDone)
  );

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [16:0] tracked;
    logic [15:0] offsetMv;
    logic disable_;
    logic resetReady;
    tracked = '0;
    offsetMv = '0;
    disable_ = 1'b0;
    resetReady = 1'b0;
    next_state = state;
    next_state.resetPulse = 1'b0;

    // Host writes to the control register; status ignores writes
    if (regWrite && regAddr == crg_pkg::CTRL3_ADDR) begin
      next_state.ctrl = regWriteData;
    end // Writes to STATUS0_ADDR fall through untouched

    // Detection completion clears the request unless a new one lands
    if (detectDone && !(regWrite && regAddr == crg_pkg::CTRL3_ADDR
        && regWriteData[crg_pkg::DETECT_BIT])) begin
      next_state.ctrl[crg_pkg::DETECT_BIT] = 1'b0;
    end

    // Watchdog restores only its marked fields
    if (watchdogExpired) begin
      next_state.ctrl = (next_state.ctrl & ~crg_pkg::WATCHDOG_MASK)
                      | (crg_pkg::CTRL3_RESET & crg_pkg::WATCHDOG_MASK);
    end
    // Software reset wins over everything
    if (softRegReset) begin
      next_state.ctrl = crg_pkg::CTRL3_RESET;
    end

    // Ship-mode sequencer works on the settled control value
    disable_ = state.ctrl[crg_pkg::SWITCH_DIS_BIT];
    resetReady = state.ctrl[crg_pkg::RESET_ADAPTER_BIT] || !adapterPresent;
    case (state.sw)
      crg_pkg::SW_ON: begin
        next_state.switchOn = 1'b1;
        if (disable_) begin
          if (state.ctrl[crg_pkg::DELAY_SEL_BIT]) begin
            next_state.sw = crg_pkg::SW_DELAY;
          end else begin
            // Immediate open
            next_state.sw = crg_pkg::SW_PEND;
            next_state.switchOn = 1'b0;
          end
        end
      end
      crg_pkg::SW_DELAY: begin
        if (!disable_) begin
          next_state.sw = crg_pkg::SW_ON;
        end else if (delayDone || !state.ctrl[crg_pkg::DELAY_SEL_BIT]) begin
          next_state.sw = crg_pkg::SW_PEND;
          next_state.switchOn = 1'b0;
        end
      end
      crg_pkg::SW_PEND: begin
        // Switch is open; decide whether a full reset is due
        if (!disable_) begin
          next_state.sw = crg_pkg::SW_ON;
          next_state.switchOn = 1'b1;
        end else if (state.ctrl[crg_pkg::SYS_RESET_EN_BIT] && resetReady) begin
          // Reset-with-adapter set, or the adapter already removed
          next_state.resetPulse = 1'b1;
          next_state.sw = crg_pkg::SW_OFF;
        end
      end
      crg_pkg::SW_OFF: begin
        // Full reset done: close the switch again and leave ship mode
        next_state.sw = crg_pkg::SW_ON;
        next_state.switchOn = 1'b1;
        if (!softRegReset) begin
          next_state.ctrl[crg_pkg::SWITCH_DIS_BIT] = 1'b0;
        end
      end
      default: begin
        next_state.sw = crg_pkg::SW_ON;
        next_state.switchOn = 1'b1;
      end
    endcase

    // Detection only forced while an adapter is present
    next_state.detectReq = state.ctrl[crg_pkg::DETECT_BIT] && adapterPresent;

    // Slowed safety timer condition
    next_state.halfRate = state.ctrl[crg_pkg::HALF_RATE_BIT]
                        && (inInputDpm || tempCoolWarm || thermalReg);

    // Battery tracking of the input voltage limit
    case (state.ctrl[crg_pkg::TRACK_HI:crg_pkg::TRACK_LO])
      2'h1: offsetMv = crg_pkg::TRACK_MV_01;
      2'h2: offsetMv = crg_pkg::TRACK_MV_10;
      2'h3: offsetMv = crg_pkg::TRACK_MV_11;
      default: offsetMv = '0;
    endcase
    tracked = {1'b0, batteryMv} + {1'b0, offsetMv};
    if (offsetMv == '0) begin
      next_state.limit = inputLimitMv; // Tracking disabled
    end else if (tracked > {1'b0, inputLimitMv}) begin
      // Saturate rather than wrap on overflow
      next_state.limit = tracked[16] ? 16'hFFFF : tracked[15:0];
    end else begin
      next_state.limit = inputLimitMv;
    end

    // Live status capture, reset clears it to zero
    next_state.status[crg_pkg::SRC_HI:crg_pkg::SRC_LO] = sourceType;
    next_state.status[crg_pkg::PHASE_HI:crg_pkg::PHASE_LO] = chargePhase;
    next_state.status[crg_pkg::PGOOD_BIT] = powerGood;
    next_state.status[crg_pkg::THERM_BIT] = thermalReg;
    next_state.status[crg_pkg::MINSYS_BIT] = minSysReg;

    // Read path; unmapped addresses read zero
    if (regRead) begin
      if (regAddr == crg_pkg::CTRL3_ADDR) begin
        next_state.readData = state.ctrl;
      end else if (regAddr == crg_pkg::STATUS0_ADDR) begin
        next_state.readData = state.status;
      end else begin
        next_state.readData = '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state.ctrl <= crg_pkg::CTRL3_RESET;
      state.status <= '0;
      state.readData <= '0;
      state.sw <= crg_pkg::SW_ON;
      state.switchOn <= 1'b1;
      state.resetPulse <= 1'b0;
      state.detectReq <= 1'b0;
      state.halfRate <= 1'b0;
      state.limit <= '0;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign regReadData = state.readData;
  assign controlValue = state.ctrl;
  assign detectRequest = state.detectReq;
  assign timerHalfRate = state.halfRate;
  assign batterySwitchOn = state.switchOn;
  assign systemResetStart = state.resetPulse;
  assign effectiveLimitMv = state.limit;
endmodule : crg_control3_status0_regs

/* File: crg_regs_chk.sv */
// Purpose: Port assertions for the control 3 / status 0 register block
// Assumes: One ref_clk domain, synchronous active-high rst
// Notes: Bound into every instance of crg_control3_status0_regs
`timescale 1ns/10ps
module crg_regs_chk #(
  parameter int SWITCH_OFF_DELAY_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  // Competing update sources
  input wire logic softRegReset,
  input wire logic watchdogExpired,
  input wire logic detectDone,
  // Outputs watched
  input wire logic [7:0] controlValue,
  input wire logic batterySwitchOn,
  input wire logic systemResetStart
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // High when only the register port may change the control byte
  wire quiet = !softRegReset && !watchdogExpired && !detectDone && !systemResetStart;
  wire ctlWr = regWrite && regAddr == 8'h07 && quiet;
  // Cycles a delayed open has been asked for while the switch stood closed
  int unsigned holdCnt;
  // Restarts whenever the request drops or the switch opens, like the design's delay count
  always_ff @(posedge ref_clk) begin
    if (rst || !controlValue[5] || !controlValue[3] || !batterySwitchOn) begin
      holdCnt <= 32'h0;
    end else begin
      holdCnt <= holdCnt + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_ro; regWrite && regAddr == 8'h08 && quiet |=> $stable(controlValue); endproperty
  a_ro: assert property (p_ro) else $error("status write altered control");
  property p_wr; ctlWr |=> controlValue == $past(regWriteData); endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_rdc; regRead && regAddr == 8'h07 |=> regReadData == $past(controlValue); endproperty
  a_rdc: assert property (p_rdc) else $error("control readback wrong");
  property p_rdn; regRead && regAddr != 8'h07 && regAddr != 8'h08 |=> regReadData == 8'h00; endproperty
  a_rdn: assert property (p_rdn) else $error("unmapped read not zero");
  // Immediate select must open the switch within a few cycles
  property p_now; ctlWr && regWriteData[5] && !regWriteData[3] |-> ##[1:3] !batterySwitchOn; endproperty
  a_now: assert property (p_now) else $error("switch not opened at once");
  // Delayed select keeps the switch closed well past the write
  // A later switch to immediate open is legal, so only a standing delay select must keep it closed
  property p_wait; ctlWr && regWriteData[5] && regWriteData[3] && !controlValue[5]
    |=> (batterySwitchOn || !controlValue[3])[*8];
  endproperty
  a_wait: assert property (p_wait) else $error("switch opened before delay");
  property p_pulse; systemResetStart |=> !systemResetStart && batterySwitchOn && !controlValue[5]; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse did not close switch");
  // The pulse was decided on the control byte of the previous cycle, which a write may since have changed
  property p_cause; $rose(systemResetStart) |-> $past(controlValue[5]) && $past(controlValue[2]) && !batterySwitchOn;
  endproperty
  a_cause: assert property (p_cause) else $error("reset pulse without enable");
  // A delayed open never comes before the delay count, nor long after it
  property p_early; $fell(batterySwitchOn) && $past(controlValue[3]) |-> holdCnt >= SWITCH_OFF_DELAY_CYCLES;
  endproperty
  a_early: assert property (p_early) else $error("switch opened before delay count");
  property p_late; holdCnt <= SWITCH_OFF_DELAY_CYCLES + 2; endproperty
  a_late: assert property (p_late) else $error("switch open overdue after delay");
  c_pulse: cover property (systemResetStart);
  c_off: cover property ($fell(batterySwitchOn));
  c_rdn: cover property (regRead && regAddr == 8'h09);
endmodule : crg_regs_chk
bind crg_control3_status0_regs crg_regs_chk #(.SWITCH_OFF_DELAY_CYCLES(SWITCH_OFF_DELAY_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
  .regRead(regRead), .regReadData(regReadData), .softRegReset(softRegReset),
  .watchdogExpired(watchdogExpired), .detectDone(detectDone), .controlValue(controlValue),
  .batterySwitchOn(batterySwitchOn), .systemResetStart(systemResetStart));

/* File: crg_host_model.sv */
// Purpose: Host side of the register port, single-byte transfers
// Assumes: Strobes taken on the rising edge after they are raised
// Notes: Idle lines carry the inverse of the last value
`timescale 1ns/10ps
module crg_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port, host side
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWriteData,
  output logic regRead,
  input wire logic [7:0] regReadData
);
  // Idle at time zero
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWriteData = 8'h00;
    regRead = 1'b0;
  end
  // One write strobe, then scramble so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWriteData <= ~d;
  endtask : wr
  // Read data stands from the edge that takes the strobe, so it is picked up one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge ref_clk);
    d = regReadData;
  endtask : rd
endmodule : crg_host_model

/* File: tb.sv */
// Purpose: Self-checking bench for the control 3 / status 0 registers
// Assumes: Short switch-off delay so ship mode runs quickly
// Notes: Random status and control values from a fixed seed
`timescale 1ns/10ps
module tb;
  localparam int DLY = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWriteData, regReadData, controlValue, rv, d;
  logic regWrite, regRead, detectRequest, timerHalfRate, batterySwitchOn, systemResetStart;
  logic softRegReset = 1'b0, watchdogExpired = 1'b0, adapterPresent = 1'b0, detectDone = 1'b0;
  logic powerGood = 1'b0, thermalReg = 1'b0, minSysReg = 1'b0, inInputDpm = 1'b0, tempCoolWarm = 1'b0;
  logic [2:0] sourceType = 3'h0;
  logic [1:0] chargePhase = 2'h0;
  logic [15:0] inputLimitMv = 16'h0000, batteryMv = 16'h0000, effectiveLimitMv;
  int miscompares = 0, n_compared = 0, pulses = 0;
  always #12.5 ref_clk = ~ref_clk;
  crg_control3_status0_regs #(.SWITCH_OFF_DELAY_CYCLES(DLY)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .regReadData(regReadData), .softRegReset(softRegReset), .watchdogExpired(watchdogExpired),
    .adapterPresent(adapterPresent), .detectDone(detectDone), .sourceType(sourceType),
    .chargePhase(chargePhase), .powerGood(powerGood), .thermalReg(thermalReg), .minSysReg(minSysReg),
    .inInputDpm(inInputDpm), .tempCoolWarm(tempCoolWarm), .inputLimitMv(inputLimitMv),
    .batteryMv(batteryMv), .controlValue(controlValue), .detectRequest(detectRequest),
    .timerHalfRate(timerHalfRate), .batterySwitchOn(batterySwitchOn),
    .systemResetStart(systemResetStart), .effectiveLimitMv(effectiveLimitMv));
  crg_host_model u_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData));
  // Count full system reset pulses
  always @(posedge ref_clk) if (systemResetStart === 1'b1) pulses++;
  ////////////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic sw(input logic e);
    chk({15'h0000, batterySwitchOn}, {15'h0000, e});
  endtask : sw
  // Larger of programmed limit and battery plus offset, saturating
  function automatic logic [15:0] lim(input logic [1:0] t, input logic [15:0] v, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, b} + (t == 2'h1 ? 17'h000C8 : t == 2'h2 ? 17'h000FA : 17'h0012C);
    if (s > 17'h0FFFF) s = 17'h0FFFF;
    return (t == 2'h0 || v > s[15:0]) ? v : s[15:0];
  endfunction : lim
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Hang guard
  initial begin
    tk(6000);
    miscompares++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h0E82E7EF));
    tk(4);
    rst <= 1'b0;
    tk(1);
    u_host.rd(8'h07, rv);
    chk({8'h00, rv}, 16'h004C);
    u_host.rd(8'h09, rv);
    chk({8'h00, rv}, 16'h0000);
    u_host.wr(8'h08, 8'hFF);
    tk(1);
    chk({8'h00, controlValue}, 16'h004C);
    $display("test reset done");
    // Ship-mode and detect bits kept low here
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom) & 8'h5F;
      @(posedge ref_clk);
      {sourceType, chargePhase, powerGood, thermalReg, minSysReg} <= 8'($urandom);
      {inInputDpm, tempCoolWarm} <= 2'($urandom);
      inputLimitMv <= 16'($urandom);
      batteryMv <= 16'($urandom);
      u_host.wr(8'h07, d);
      tk(2);
      u_host.rd(8'h07, rv);
      chk({8'h00, rv}, {8'h00, d});
      u_host.rd(8'h08, rv);
      chk({8'h00, rv}, {8'h00, sourceType, chargePhase, powerGood, thermalReg, minSysReg});
      chk(effectiveLimitMv, lim(d[1:0], inputLimitMv, batteryMv));
      chk({15'h0000, timerHalfRate}, {15'h0000, d[6] & (inInputDpm | tempCoolWarm | thermalReg)});
    end
    $display("test random done");
    u_host.wr(8'h07, 8'h1B);
    @(posedge ref_clk) watchdogExpired <= 1'b1;
    @(posedge ref_clk) watchdogExpired <= 1'b0;
    tk(1);
    chk({8'h00, controlValue}, 16'h005F);
    @(posedge ref_clk) softRegReset <= 1'b1;
    @(posedge ref_clk) softRegReset <= 1'b0;
    tk(1);
    chk({8'h00, controlValue}, 16'h004C);
    @(posedge ref_clk) adapterPresent <= 1'b1;
    u_host.wr(8'h07, 8'hCC);
    tk(3);
    chk({15'h0000, detectRequest}, 16'h0001);
    @(posedge ref_clk) detectDone <= 1'b1;
    @(posedge ref_clk) detectDone <= 1'b0;
    tk(1);
    chk({8'h00, controlValue}, 16'h004C);
    $display("test resets done");
    u_host.wr(8'h07, 8'h20);
    tk(4);
    sw(1'b0);
    u_host.wr(8'h07, 8'h00);
    tk(4);
    sw(1'b1);
    u_host.wr(8'h07, 8'h28);
    tk(DLY / 2);
    u_host.wr(8'h07, 8'h08);
    tk(DLY + 4);
    sw(1'b1);
    u_host.wr(8'h07, 8'h28);
    tk(DLY - 4);
    sw(1'b1);
    tk(10);
    sw(1'b0);
    $display("test ship done");
    u_host.wr(8'h07, 8'h24);
    tk(10);
    chk(16'(pulses), 16'h0000);
    @(posedge ref_clk) adapterPresent <= 1'b0;
    tk(5);
    chk(16'(pulses), 16'h0001);
    sw(1'b1);
    @(posedge ref_clk) adapterPresent <= 1'b1;
    u_host.wr(8'h07, 8'h14);
    u_host.wr(8'h07, 8'h34);
    tk(5);
    chk(16'(pulses), 16'h0002);
    u_host.wr(8'h07, 8'h30);
    tk(8);
    chk(16'(pulses), 16'h0002);
    sw(1'b0);
    $display("test system reset done");
    end_sim;
  end
endmodule : tb
